// *** src/ssidr_pkg.sv ***
package ssidr_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_SET = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_RX_ADDR = 8'h20;
  localparam logic [7:0] OFF_RX_CNT = 8'h24;
  localparam logic [7:0] OFF_TX_ADDR = 8'h28;
  localparam logic [7:0] OFF_TX_CNT = 8'h2C;

  // status and mask bit positions
  localparam int BIT_RX_FULL = 0;
  localparam int BIT_TX_EMPTY = 1;
  localparam int BIT_MODE_FAULT = 2;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_RX_DONE = 4;
  localparam int BIT_TX_DONE = 5;
  localparam int BIT_ENABLED = 16;
  localparam int NUM_SRC = 6;

  // values after reset
  localparam logic [5:0] RST_MASK = 6'h00;
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // events from the rest of the unit, one-cycle pulses on mclk_i
  typedef struct packed {
    logic rx_load;
    logic tx_take;
    logic rx_data_read;
    logic tx_data_write;
    logic enable_cmd;
    logic disable_cmd;
    logic soft_reset;
  } ssidr_unit_s;

  // one buffer transfer channel as seen from this block
  typedef struct packed {
    logic step;
    logic end_of_transfer;
  } ssidr_chan_in_s;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [15:0] count;
  } ssidr_chan_out_s;

endpackage

// *** src/ssidr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssidr_sync (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic async_i,
  output logic level_o
);

  logic [2:0] stage_r;
  logic level_r;

  // the level only moves once the second and third stages agree
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      stage_r <= 3'h0;
      level_r <= 1'b0;
    end else if (ce_i) begin
      stage_r <= {stage_r[1:0], async_i};
      if (stage_r[1] == stage_r[2]) begin
        level_r <= stage_r[2];
      end
    end
  end

  assign level_o = level_r;

endmodule
`default_nettype wire

// *** src/ssidr_top.sv ***
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module ssidr_top #(
  parameter int PADDR_W = 8,
  parameter int CNT_W = 16,
  parameter logic [31:0] ADDR_STEP = 32'h0000_0002
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ssidr_pkg::ssidr_unit_s unit_i,
  input wire logic mode_fault_pin_i,
  input wire ssidr_pkg::ssidr_chan_in_s rx_chan_i,
  input wire ssidr_pkg::ssidr_chan_in_s tx_chan_i,
  output ssidr_pkg::ssidr_chan_out_s rx_chan_o,
  output ssidr_pkg::ssidr_chan_out_s tx_chan_o,
  output logic enabled_o,
  output logic irq_o
);

  // refuse widths that the decoder and the count registers cannot hold, and a zero address step
  if (PADDR_W < 8 || PADDR_W > 32) begin : g_bad_paddr
    $error("PADDR_W must lie between 8 and 32");
  end
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 16");
  end
  if (ADDR_STEP == 32'h0000_0000) begin : g_bad_step
    $error("ADDR_STEP must not be zero");
  end

  typedef struct packed {
    logic [ssidr_pkg::NUM_SRC-1:0] mask;
    logic rx_full;
    logic tx_empty;
    logic mode_fault;
    logic overrun;
    logic enabled;
    logic fault_level;
    logic [31:0] rx_addr;
    logic [31:0] tx_addr;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] tx_cnt;
    logic [ssidr_pkg::NUM_SRC-1:0] shown;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_req;
    logic tx_req;
    logic irq;
  } ssidr_state_s;

  ssidr_state_s state_r;
  ssidr_state_s state_nxt;
  logic fault_pin_level;

  // mode fault arrives on a pin, so it is synchronised first
  ssidr_sync u_fault_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .async_i(mode_fault_pin_i),
    .level_o(fault_pin_level)
  );

  function automatic logic hits(input logic [PADDR_W-1:0] addr, input logic [7:0] off);
    logic [PADDR_W-1:0] wide;
    wide = '0;
    wide[7:0] = off;
    hits = (addr[PADDR_W-1:2] == wide[PADDR_W-1:2]);
  endfunction

  function automatic logic [31:0] pad_cnt(input logic [CNT_W-1:0] cnt);
    logic [31:0] word;
    word = ssidr_pkg::RST_WORD;
    word[CNT_W-1:0] = cnt;
    pad_cnt = word;
  endfunction

  // live status word, shared by the read path and the reported-bit capture
  function automatic logic [31:0] status_word(input ssidr_state_s s, input logic rx_end, input logic tx_end);
    logic [31:0] word;
    word = ssidr_pkg::RST_WORD;
    word[ssidr_pkg::BIT_RX_FULL] = s.rx_full;
    word[ssidr_pkg::BIT_TX_EMPTY] = s.tx_empty;
    word[ssidr_pkg::BIT_MODE_FAULT] = s.mode_fault;
    word[ssidr_pkg::BIT_OVERRUN] = s.overrun;
    word[ssidr_pkg::BIT_RX_DONE] = rx_end;
    word[ssidr_pkg::BIT_TX_DONE] = tx_end;
    word[ssidr_pkg::BIT_ENABLED] = s.enabled;
    status_word = word;
  endfunction

  // channel arithmetic, shared by the receive and transmit halves
  function automatic logic [31:0] next_addr(input logic [31:0] addr);
    next_addr = addr + ADDR_STEP;
  endfunction

  function automatic logic [CNT_W-1:0] next_cnt(input logic [CNT_W-1:0] cnt);
    next_cnt = cnt - CNT_W'(1);
  endfunction

  // a zero count stops the channel whatever its flag says
  function automatic logic chan_req(input logic [CNT_W-1:0] cnt, input logic flag);
    chan_req = (cnt != '0) && flag;
  endfunction

  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  logic fault_event;
  logic status_rd;
  logic [31:0] live_status;
  logic [ssidr_pkg::NUM_SRC-1:0] src;
  // one select per register, decoded once for the read and the write paths
  logic sel_status;
  logic sel_irq_set;
  logic sel_irq_clr;
  logic sel_irq_mask;
  logic sel_rx_addr;
  logic sel_rx_cnt;
  logic sel_tx_addr;
  logic sel_tx_cnt;

  always_comb begin
    state_nxt = state_r;
    access = psel_i && penable_i;
    done = access && state_r.pready;
    wr_done = done && pwrite_i;
    rd_done = done && !pwrite_i;
    sel_status = hits(paddr_i, ssidr_pkg::OFF_STATUS);
    sel_irq_set = hits(paddr_i, ssidr_pkg::OFF_IRQ_SET);
    sel_irq_clr = hits(paddr_i, ssidr_pkg::OFF_IRQ_CLR);
    sel_irq_mask = hits(paddr_i, ssidr_pkg::OFF_IRQ_MASK);
    sel_rx_addr = hits(paddr_i, ssidr_pkg::OFF_RX_ADDR);
    sel_rx_cnt = hits(paddr_i, ssidr_pkg::OFF_RX_CNT);
    sel_tx_addr = hits(paddr_i, ssidr_pkg::OFF_TX_ADDR);
    sel_tx_cnt = hits(paddr_i, ssidr_pkg::OFF_TX_CNT);
    mapped = sel_status || sel_irq_set || sel_irq_clr || sel_irq_mask ||
             sel_rx_addr || sel_rx_cnt || sel_tx_addr || sel_tx_cnt;
    fault_event = fault_pin_level && !state_r.fault_level;
    status_rd = rd_done && sel_status;
    live_status = status_word(state_r, rx_chan_i.end_of_transfer, tx_chan_i.end_of_transfer);
    state_nxt.fault_level = fault_pin_level;

    // apb: one wait state, answer registered
    state_nxt.pready = access && !state_r.pready;
    state_nxt.pslverr = access && !state_r.pready && !mapped;
    if (access && !state_r.pready) begin
      state_nxt.prdata = ssidr_pkg::RST_WORD;
      state_nxt.shown = '0;
      if (!pwrite_i) begin
        if (sel_status) begin
          state_nxt.prdata = live_status;
          state_nxt.shown = live_status[ssidr_pkg::NUM_SRC-1:0];
        end else if (sel_irq_mask) begin
          state_nxt.prdata[ssidr_pkg::NUM_SRC-1:0] = state_r.mask;
        end else if (sel_rx_addr) begin
          state_nxt.prdata = state_r.rx_addr;
        end else if (sel_rx_cnt) begin
          state_nxt.prdata = pad_cnt(state_r.rx_cnt);
        end else if (sel_tx_addr) begin
          state_nxt.prdata = state_r.tx_addr;
        end else if (sel_tx_cnt) begin
          state_nxt.prdata = pad_cnt(state_r.tx_cnt);
        end
      end
    end

    // mask register
    if (wr_done && sel_irq_set) begin
      state_nxt.mask = state_r.mask | pwdata_i[ssidr_pkg::NUM_SRC-1:0];
    end
    if (wr_done && sel_irq_clr) begin
      state_nxt.mask = state_r.mask & ~pwdata_i[ssidr_pkg::NUM_SRC-1:0];
    end

    // enable state, disable wins when both commands arrive together
    if (unit_i.enable_cmd) begin
      state_nxt.enabled = 1'b1;
    end
    if (unit_i.disable_cmd) begin
      state_nxt.enabled = 1'b0;
    end

    // receive-full: the load wins over a read in the same cycle
    if (unit_i.rx_data_read) begin
      state_nxt.rx_full = 1'b0;
    end
    if (unit_i.rx_load) begin
      state_nxt.rx_full = 1'b1;
    end

    // transmit-empty: serializer take wins over a write in the same cycle
    if (unit_i.tx_data_write) begin
      state_nxt.tx_empty = 1'b0;
    end
    if (unit_i.tx_take) begin
      state_nxt.tx_empty = 1'b1;
    end
    if (unit_i.enable_cmd && !unit_i.disable_cmd) begin
      state_nxt.tx_empty = 1'b1;
    end
    if (!state_nxt.enabled) begin
      state_nxt.tx_empty = 1'b0;
    end

    // sticky errors: a status read clears only what it reported, new events win
    if (status_rd && state_r.shown[ssidr_pkg::BIT_MODE_FAULT]) begin
      state_nxt.mode_fault = 1'b0;
    end
    if (fault_event) begin
      state_nxt.mode_fault = 1'b1;
    end
    if (status_rd && state_r.shown[ssidr_pkg::BIT_OVERRUN]) begin
      state_nxt.overrun = 1'b0;
    end
    if (unit_i.rx_load && state_r.rx_full && !unit_i.rx_data_read) begin
      state_nxt.overrun = 1'b1;
    end

    // receive channel pointer and counter
    if (rx_chan_i.step && state_r.rx_cnt != '0) begin
      state_nxt.rx_addr = next_addr(state_r.rx_addr);
      state_nxt.rx_cnt = next_cnt(state_r.rx_cnt);
    end
    if (wr_done && sel_rx_addr) begin
      state_nxt.rx_addr = pwdata_i;
    end
    if (wr_done && sel_rx_cnt) begin
      state_nxt.rx_cnt = pwdata_i[CNT_W-1:0];
    end

    // transmit channel pointer and counter
    if (tx_chan_i.step && state_r.tx_cnt != '0) begin
      state_nxt.tx_addr = next_addr(state_r.tx_addr);
      state_nxt.tx_cnt = next_cnt(state_r.tx_cnt);
    end
    if (wr_done && sel_tx_addr) begin
      state_nxt.tx_addr = pwdata_i;
    end
    if (wr_done && sel_tx_cnt) begin
      state_nxt.tx_cnt = pwdata_i[CNT_W-1:0];
    end

    // channel requests, a zero count stops the channel
    state_nxt.rx_req = chan_req(state_nxt.rx_cnt, state_nxt.rx_full);
    state_nxt.tx_req = chan_req(state_nxt.tx_cnt, state_nxt.tx_empty);

    // interrupt from the next flags so it tracks status bits 0 to 3 exactly; the done bits come from the live end-of-transfer inputs and lag by a cycle
    src = '0;
    src[ssidr_pkg::BIT_RX_FULL] = state_nxt.rx_full;
    src[ssidr_pkg::BIT_TX_EMPTY] = state_nxt.tx_empty;
    src[ssidr_pkg::BIT_MODE_FAULT] = state_nxt.mode_fault;
    src[ssidr_pkg::BIT_OVERRUN] = state_nxt.overrun;
    src[ssidr_pkg::BIT_RX_DONE] = rx_chan_i.end_of_transfer;
    src[ssidr_pkg::BIT_TX_DONE] = tx_chan_i.end_of_transfer;
    state_nxt.irq = |(src & state_nxt.mask);

    // software reset returns every register except the apb answer, shown and fault_level to its reset value
    if (unit_i.soft_reset) begin
      state_nxt.mask = ssidr_pkg::RST_MASK;
      state_nxt.rx_full = 1'b0;
      state_nxt.tx_empty = 1'b0;
      state_nxt.mode_fault = 1'b0;
      state_nxt.overrun = 1'b0;
      state_nxt.enabled = 1'b0;
      state_nxt.rx_addr = ssidr_pkg::RST_ADDR;
      state_nxt.tx_addr = ssidr_pkg::RST_ADDR;
      state_nxt.rx_cnt = '0;
      state_nxt.tx_cnt = '0;
      state_nxt.rx_req = 1'b0;
      state_nxt.tx_req = 1'b0;
      state_nxt.irq = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      state_r.mask <= ssidr_pkg::RST_MASK;
      state_r.rx_full <= 1'b0;
      state_r.tx_empty <= 1'b0;
      state_r.mode_fault <= 1'b0;
      state_r.overrun <= 1'b0;
      state_r.enabled <= 1'b0;
      state_r.fault_level <= 1'b0;
      state_r.rx_addr <= ssidr_pkg::RST_ADDR;
      state_r.tx_addr <= ssidr_pkg::RST_ADDR;
      state_r.rx_cnt <= '0;
      state_r.tx_cnt <= '0;
      state_r.shown <= '0;
      state_r.prdata <= ssidr_pkg::RST_WORD;
      state_r.pready <= 1'b0;
      state_r.pslverr <= 1'b0;
      state_r.rx_req <= 1'b0;
      state_r.tx_req <= 1'b0;
      state_r.irq <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  assign prdata_o = state_r.prdata;
  assign pready_o = state_r.pready;
  assign pslverr_o = state_r.pslverr;
  assign rx_chan_o.req = state_r.rx_req;
  assign rx_chan_o.addr = state_r.rx_addr;
  assign rx_chan_o.count = 16'(pad_cnt(state_r.rx_cnt));
  assign tx_chan_o.req = state_r.tx_req;
  assign tx_chan_o.addr = state_r.tx_addr;
  assign tx_chan_o.count = 16'(pad_cnt(state_r.tx_cnt));
  assign enabled_o = state_r.enabled;
  assign irq_o = state_r.irq;

endmodule
`default_nettype wire

// *** tb/ssidr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssidr_checker #(
  parameter int PADDR_W = 8
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [PADDR_W-1:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire ssidr_pkg::ssidr_unit_s unit_i,
  input wire ssidr_pkg::ssidr_chan_in_s rx_chan_i,
  input wire ssidr_pkg::ssidr_chan_out_s rx_chan_o,
  input wire ssidr_pkg::ssidr_chan_out_s tx_chan_o,
  input wire logic enabled_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);
  property p_ready; psel_i && $rose(penable_i) |=> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_pulse; pready_o |=> !pready_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_err; pready_o |-> pslverr_o == (paddr_i < 8'h10 || paddr_i > 8'h2F); endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_rx_req; unit_i.rx_load && rx_chan_o.count != 16'h0 && !rx_chan_i.step |-> ##[1:2] rx_chan_o.req;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx request missing");
  property p_rx_off; rx_chan_o.count == 16'h0 && $past(rx_chan_o.count) == 16'h0 |-> !rx_chan_o.req; endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx request at zero");
  property p_tx_off; tx_chan_o.count == 16'h0 && $past(tx_chan_o.count) == 16'h0 |-> !tx_chan_o.req; endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx request at zero");
  property p_en; unit_i.enable_cmd && !unit_i.disable_cmd && !unit_i.soft_reset |=> enabled_o; endproperty
  a_en: assert property (p_en) else $error("enable lost");
  property p_dis; unit_i.disable_cmd |=> !enabled_o; endproperty
  a_dis: assert property (p_dis) else $error("disable lost");
  property p_tx_en; !enabled_o && unit_i.enable_cmd && !unit_i.disable_cmd && !unit_i.soft_reset
    && tx_chan_o.count != 16'h0 |-> ##[1:2] tx_chan_o.req; endproperty
  a_tx_en: assert property (p_tx_en) else $error("tx empty not forced");
  property p_tx_dis; (!enabled_o && !unit_i.enable_cmd) [*2] |=> !tx_chan_o.req; endproperty
  a_tx_dis: assert property (p_tx_dis) else $error("tx request while off");
  property p_step; rx_chan_i.step && rx_chan_o.count != 16'h0 && !(psel_i && pwrite_i) |=>
    rx_chan_o.count == $past(rx_chan_o.count) - 16'h1 && rx_chan_o.addr == $past(rx_chan_o.addr) + 32'h2;
  endproperty
  a_step: assert property (p_step) else $error("channel step wrong");
endmodule
`default_nettype wire

// *** tb/ssidr_chan_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ssidr_chan_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic slow_i,
  input wire ssidr_pkg::ssidr_chan_out_s chan_i,
  output ssidr_pkg::ssidr_chan_in_s chan_o,
  output logic xfer_o
);
  logic [3:0] hold;
  // gap after each word so a stale request is not served twice
  always_ff @(posedge mclk_i) begin
    chan_o.step <= 1'b0;
    if (!resetn_i) begin
      hold <= 4'h0;
      chan_o.end_of_transfer <= 1'b0;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end else if (chan_i.req && chan_i.count != 16'h0) begin
      chan_o.step <= 1'b1;
      hold <= slow_i ? 4'h9 : 4'h3;
      chan_o.end_of_transfer <= (chan_i.count == 16'h1);
    end else if (chan_i.count != 16'h0) begin
      chan_o.end_of_transfer <= 1'b0;
    end
  end
  assign xfer_o = chan_o.step;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mfp = 1'b0;
  logic ce = 1'b1;
  ssidr_pkg::ssidr_unit_s ev = 7'h00;
  ssidr_pkg::ssidr_unit_s u;
  ssidr_pkg::ssidr_chan_in_s rx_ci;
  ssidr_pkg::ssidr_chan_in_s tx_ci;
  ssidr_pkg::ssidr_chan_out_s rx_co;
  ssidr_pkg::ssidr_chan_out_s tx_co;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic err;
  logic enabled;
  logic irq;
  logic rx_rd;
  logic tx_wr;
  int fail_count = 0;
  int total_checks = 0;
  initial forever #10 mclk_i = ~mclk_i;
  // channel moves read the receive register and write the transmit register
  always_comb begin
    u = ev;
    u.rx_data_read = ev.rx_data_read | rx_rd;
    u.tx_data_write = ev.tx_data_write | tx_wr;
  end
  ssidr_top u_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .unit_i(u), .mode_fault_pin_i(mfp), .rx_chan_i(rx_ci), .tx_chan_i(tx_ci),
    .rx_chan_o(rx_co), .tx_chan_o(tx_co), .enabled_o(enabled), .irq_o(irq)
  );
  ssidr_chan_model u_rxm (.mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(1'b1), .chan_i(rx_co),
    .chan_o(rx_ci), .xfer_o(rx_rd));
  ssidr_chan_model u_txm (.mclk_i(mclk_i), .resetn_i(resetn_i), .slow_i(1'b0), .chan_i(tx_co),
    .chan_o(tx_ci), .xfer_o(tx_wr));
  task automatic test_done();
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fail_count++;
      test_done();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic pulse(input ssidr_pkg::ssidr_unit_s e);
    @(posedge mclk_i);
    ev <= e;
    @(posedge mclk_i);
    ev <= 7'h00;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk_i);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic wait_cnt(input logic tx, input logic [15:0] c);
    int n;
    n = 0;
    while ((tx ? tx_co.count : rx_co.count) !== c && n < 300) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 300) begin
      fail_count++;
      test_done();
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'h10 + 8'(i * 4), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("error flag", 32'h1, {31'h0, err});
    apb(1'b1, 8'h14, 32'h5);
    apb(1'b1, 8'h14, 32'h22);
    apb(1'b1, 8'h1C, 32'h0);
    rd(8'h1C, 32'h27);
    apb(1'b1, 8'h18, 32'h3);
    rd(8'h1C, 32'h24);
    pulse(7'h04);
    rd(8'h10, 32'h10002);
    apb(1'b1, 8'h14, 32'h2);
    irq_is(1'b1);
    apb(1'b1, 8'h18, 32'h2);
    irq_is(1'b0);
    pulse(7'h08);
    rd(8'h10, 32'h10000);
    pulse(7'h20);
    rd(8'h10, 32'h10002);
    pulse(7'h08);
    pulse(7'h04);
    rd(8'h10, 32'h10002);
    pulse(7'h40);
    rd(8'h10, 32'h10003);
    pulse(7'h40);
    rd(8'h10, 32'h1000B);
    rd(8'h10, 32'h10003);
    pulse(7'h10);
    rd(8'h10, 32'h10002);
    // a load while the clock enable is low must leave no trace
    ce <= 1'b0;
    pulse(7'h40);
    @(posedge mclk_i);
    ce <= 1'b1;
    rd(8'h10, 32'h10002);
    @(posedge mclk_i);
    mfp <= 1'b1;
    repeat (8) @(posedge mclk_i);
    mfp <= 1'b0;
    irq_is(1'b1);
    rd(8'h10, 32'h10006);
    rd(8'h10, 32'h10002);
    irq_is(1'b0);
    apb(1'b1, 8'h20, 32'h100);
    apb(1'b1, 8'h24, 32'h2);
    pulse(7'h40);
    wait_cnt(1'b0, 16'h1);
    pulse(7'h40);
    wait_cnt(1'b0, 16'h0);
    rd(8'h20, 32'h104);
    rd(8'h10, 32'h10012);
    apb(1'b1, 8'h28, 32'h200);
    apb(1'b1, 8'h2C, 32'h1);
    wait_cnt(1'b1, 16'h0);
    rd(8'h28, 32'h202);
    rd(8'h10, 32'h10030);
    irq_is(1'b1);
    pulse(7'h20);
    rd(8'h10, 32'h10032);
    apb(1'b1, 8'h18, 32'h3F);
    pulse(7'h02);
    rd(8'h10, 32'h30);
    apb(1'b1, 8'h2C, 32'h1);
    rd(8'h2C, 32'h1);
    pulse(7'h04);
    wait_cnt(1'b1, 16'h0);
    rd(8'h10, 32'h10030);
    chk("enabled", 32'h1, {31'h0, enabled});
    apb(1'b1, 8'h14, 32'h3F);
    irq_is(1'b1);
    pulse(7'h01);
    rd(8'h1C, 32'h0);
    rd(8'h10, 32'h30);
    chk("enabled", 32'h0, {31'h0, enabled});
    irq_is(1'b0);
    test_done();
  end
endmodule
bind ssidr_top ssidr_checker #(.PADDR_W(PADDR_W)) u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .unit_i(unit_i), .rx_chan_i(rx_chan_i),
  .rx_chan_o(rx_chan_o), .tx_chan_o(tx_chan_o), .enabled_o(enabled_o)
);
`default_nettype wire
